// ---- core/strap_pkg.sv ----
/*
 * constants shared by the strap and status pin logic: reset values,
 * strap bit positions and the collision indicator hold time.
 * assumes a single 250 MHz core clock.
 */
package strap_pkg;

    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int unsigned CLK_FREQ_HZ      = 250_000_000;
    localparam int unsigned COLL_HOLD_MS     = 70;
    localparam int unsigned COLL_HOLD_CYCLES =
        COLL_HOLD_MS * (CLK_FREQ_HZ / 1000);

    // ****************************************************************
    // management address bit positions carried by the strap pins
    // ****************************************************************
    localparam int unsigned ADDR1_POS = 1;
    localparam int unsigned ADDR4_POS = 4;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic STRAP_RST    = 1'b0;
    localparam logic PIN_OE_N_RST = 1'b1;
    localparam logic LED_RST      = 1'b0;
    localparam logic SPEED_RST    = 1'b0;

    // ****************************************************************
    // pin phase
    // ****************************************************************
    typedef enum logic [0:0] {
        PHASE_STRAP  = 1'b0,
        PHASE_STATUS = 1'b1
    } pin_phase_t;

endpackage

// ---- core/stretch_if.sv ----
/*
 * event to stretched level carrier between the pin logic and its
 * pulse stretcher.
 * assumes both ends share one clock.
 */
`timescale 1ns/100ps

interface stretch_if;

    logic trigger;
    logic active;

    modport src
    (
        output trigger,
        input  active
    );

    modport snk
    (
        input  trigger,
        output active
    );

endinterface

// ---- core/pulse_stretcher.sv ----
/*
 * holds a level for a fixed number of cycles after each trigger.
 * assumes triggers synchronous to clock_i; ce_i low freezes it.
 */
`timescale 1ns/100ps

module pulse_stretcher
#(
    parameter int unsigned HOLD_CYCLES = strap_pkg::COLL_HOLD_CYCLES
)
(
    // clock and reset
    input  wire logic   clock_i,
    input  wire logic   rst_n_i,
    input  wire logic   ce_i,
    // event in, level out
    stretch_if.snk      s
);

    localparam int unsigned W = $clog2(HOLD_CYCLES + 1);

    logic [W-1:0] cnt_q;

    // ****************************************************************
    // hold counter, retriggered by every new event
    // ****************************************************************
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cnt_q <= '0;
        else if (ce_i)
        begin
            if (s.trigger)
                cnt_q <= W'(HOLD_CYCLES);
            else if (cnt_q != '0)
                cnt_q <= cnt_q - 1'b1;
        end
    end

    assign s.active = (cnt_q != '0);

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence trig_s;
        rst_n_i && ce_i && s.trigger;
    endsequence

    sequence count_step_s;
        rst_n_i && ce_i && !s.trigger && (cnt_q != '0);
    endsequence

    hold_load_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        trig_s |=> s.active && (cnt_q == W'(HOLD_CYCLES)))
        else $error("stretch counter not loaded on trigger");

    hold_count_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        count_step_s |=> (cnt_q == $past(cnt_q) - 1'b1))
        else $error("stretch counter did not step down by one");

endmodule // pulse_stretcher

// ---- core/strap_status_pins.sv ----
/*
 * strap and status pin logic: address straps caught at reset release,
 * then the same pins turn into activity and collision indicators;
 * also the speed indication and an operational flag.
 * assumes all inputs synchronous to clock_i and board straps that
 * hold their level through reset.
 */
// Notes on behaviour
// - rx pin is strap input during reset
// - low strap gives zero, high gives one
// - after reset the pin becomes an output
// - output follows receive activity
// - speed output low 10M, high 100M
// - reset low holds reset, high operates
// - collision indicator held about 70 ms
`timescale 1ns/100ps

module strap_status_pins
#(
    parameter int unsigned COLL_HOLD_CYCLES =
        strap_pkg::COLL_HOLD_CYCLES
)
(
    // clock, reset, enable
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    // core status in
    input  wire logic rx_activity_i,
    input  wire logic collision_i,
    input  wire logic speed_100_i,
    // receive activity / address bit 4 pin
    input  wire logic addr4_rx_activity_pin_i,
    output logic      addr4_rx_activity_pin_o,
    output logic      addr4_rx_activity_pin_oe_n_o,
    // collision / address bit 1 pin
    input  wire logic addr1_collision_pin_i,
    output logic      addr1_collision_pin_o,
    output logic      addr1_collision_pin_oe_n_o,
    // results
    output logic      addr_bit4_o,
    output logic      addr_bit1_o,
    output logic      speed_select_out_o,
    output logic      operational_o
);

    strap_pkg::pin_phase_t phase_q;
    logic                  addr4_q;
    logic                  addr1_q;
    logic                  oe_n_q;
    logic                  rx_led_q;
    logic                  coll_led_q;
    logic                  speed_q;
    logic                  oper_q;

    stretch_if coll ();

    // ****************************************************************
    // phase: strap sampling until the first enabled edge after release
    // ****************************************************************
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            phase_q <= strap_pkg::PHASE_STRAP;
        else if (ce_i)
        begin
            unique case (phase_q)
                strap_pkg::PHASE_STRAP:
                    phase_q <= strap_pkg::PHASE_STATUS;
                strap_pkg::PHASE_STATUS:
                    phase_q <= strap_pkg::PHASE_STATUS;
            endcase
        end
    end

    // ****************************************************************
    // strap capture, once per reset
    // ****************************************************************
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            addr4_q <= strap_pkg::STRAP_RST;
            addr1_q <= strap_pkg::STRAP_RST;
        end
        else if (ce_i && phase_q == strap_pkg::PHASE_STRAP)
        begin
            addr4_q <= addr4_rx_activity_pin_i;
            addr1_q <= addr1_collision_pin_i;
        end
    end

    // ****************************************************************
    // pin direction: released during reset, driven after capture
    // ****************************************************************
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            oe_n_q <= strap_pkg::PIN_OE_N_RST;
        else if (ce_i && phase_q == strap_pkg::PHASE_STRAP)
            oe_n_q <= 1'b0;
    end

    // ****************************************************************
    // indicators
    // ****************************************************************
    assign coll.trigger = collision_i;

    pulse_stretcher
    #(
        .HOLD_CYCLES (COLL_HOLD_CYCLES)
    )
    u_coll_stretch
    (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .s       (coll)
    );

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rx_led_q   <= strap_pkg::LED_RST;
            coll_led_q <= strap_pkg::LED_RST;
        end
        else if (ce_i)
        begin
            rx_led_q   <= rx_activity_i;
            coll_led_q <= coll.active;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            speed_q <= strap_pkg::SPEED_RST;
        else if (ce_i)
            speed_q <= speed_100_i;
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            oper_q <= 1'b0;
        else if (ce_i)
            oper_q <= 1'b1;
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign addr4_rx_activity_pin_o      = rx_led_q;
    assign addr4_rx_activity_pin_oe_n_o = oe_n_q;
    assign addr1_collision_pin_o        = coll_led_q;
    assign addr1_collision_pin_oe_n_o   = oe_n_q;
    assign addr_bit4_o                  = addr4_q;
    assign addr_bit1_o                  = addr1_q;
    assign speed_select_out_o           = speed_q;
    assign operational_o                = oper_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clock_i);
    endclocking

    default disable iff (!rst_n_i);

    sequence strap_edge_s;
        rst_n_i && ce_i && phase_q == strap_pkg::PHASE_STRAP;
    endsequence

    sequence status_edge_s;
        rst_n_i && ce_i && phase_q == strap_pkg::PHASE_STATUS;
    endsequence

    strap_capture_a: assert property (
        strap_edge_s |=> addr_bit4_o == $past(addr4_rx_activity_pin_i)
            && addr_bit1_o == $past(addr1_collision_pin_i))
        else $error("strap level not captured at release");

    strap_released_a: assert property (
        phase_q == strap_pkg::PHASE_STRAP
            |-> addr4_rx_activity_pin_oe_n_o)
        else $error("strap pin driven during strap phase");

    pin_drive_a: assert property (
        strap_edge_s |=> !addr4_rx_activity_pin_oe_n_o
            && !addr1_collision_pin_oe_n_o)
        else $error("pin not turned to output after reset");

    rx_indicate_a: assert property (
        status_edge_s |=> addr4_rx_activity_pin_o == $past(rx_activity_i))
        else $error("activity output does not follow receive");

    speed_indicate_a: assert property (
        rst_n_i && ce_i |=> speed_select_out_o == $past(speed_100_i))
        else $error("speed output does not follow selection");

    oper_flag_a: assert property (
        operational_o |-> phase_q == strap_pkg::PHASE_STATUS)
        else $error("operational before strap capture");

    strap_hold_a: assert property (
        phase_q == strap_pkg::PHASE_STATUS |=> $stable(addr_bit4_o)
            && $stable(addr_bit1_o))
        else $error("strap value changed after capture");

    coll_hold_a: assert property (
        rst_n_i && ce_i && collision_i ##1 ce_i |=> addr1_collision_pin_o)
        else $error("collision indicator not raised");

    coll_idle_a: assert property (
        rst_n_i && ce_i && !coll.active |=> !addr1_collision_pin_o)
        else $error("collision indicator raised without collision");

    ce_freeze_a: assert property (
        rst_n_i && !ce_i |=> $stable(addr4_rx_activity_pin_o)
            && $stable(speed_select_out_o) && $stable(addr_bit4_o))
        else $error("outputs moved while clock enable low");

endmodule // strap_status_pins

// ---- bench/board_model.sv ----
/*
 * board side of the strap pins: strap resistors and indicator loads.
 * assumes a released pin settles to its strap resistor level.
 */
`timescale 1ns/100ps

module board_model
(
    // strap levels and device drive
    input  wire logic strap4_i,
    input  wire logic strap1_i,
    input  wire logic pin4_i,
    input  wire logic oe4_n_i,
    input  wire logic pin1_i,
    input  wire logic oe1_n_i,
    // pad levels
    output logic      pad4_o,
    output logic      pad1_o
);
    // released pin reads the strap, a driven one the device level
    assign pad4_o = oe4_n_i ? strap4_i : pin4_i;
    assign pad1_o = oe1_n_i ? strap1_i : pin1_i;
endmodule // board_model

// ---- bench/test_strap_and_status_pin_logic.sv ----
/*
 * self-checking bench for the strap and status pin logic.
 * assumes the board model above and a shortened collision hold.
 */
`timescale 1ns/100ps

module test_strap_and_status_pin_logic;
    localparam int unsigned HOLD = 16;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic rx = 1'b0, coll = 1'b0, spd = 1'b0, s4 = 1'b0, s1 = 1'b0;
    logic pad4, pad1, p4o, p4oe, p1o, p1oe, a4, a1, spo, op;
    logic rx_prev, spd_prev;
    logic [7:0] rnd = 8'h1d;
    int err_count = 0;
    int check_count = 0;

    // reference clock from the board
    initial
    begin
        forever #2 clock_i = ~clock_i;
    end

    strap_status_pins #(.COLL_HOLD_CYCLES(HOLD)) u_strap_status_pins
    (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .rx_activity_i(rx), .collision_i(coll), .speed_100_i(spd),
        .addr4_rx_activity_pin_i(pad4), .addr4_rx_activity_pin_o(p4o),
        .addr4_rx_activity_pin_oe_n_o(p4oe),
        .addr1_collision_pin_i(pad1), .addr1_collision_pin_o(p1o),
        .addr1_collision_pin_oe_n_o(p1oe),
        .addr_bit4_o(a4), .addr_bit1_o(a1),
        .speed_select_out_o(spo), .operational_o(op)
    );

    board_model u_board_model
    (
        .strap4_i(s4), .strap1_i(s1), .pin4_i(p4o), .oe4_n_i(p4oe),
        .pin1_i(p1o), .oe1_n_i(p1oe), .pad4_o(pad4), .pad1_o(pad1)
    );

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check_bit(input string name, input logic exp,
                             input logic got);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic do_reset(input logic v4, input logic v1);
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        s4 <= v4;
        s1 <= v1;
        repeat (4) @(posedge clock_i);
        @(negedge clock_i);
        check_bit("oe4_n", 1'b1, p4oe);
        check_bit("oe1_n", 1'b1, p1oe);
        check_bit("oper", 1'b0, op);
        @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        @(negedge clock_i);
        check_bit("addr4", v4, a4);
        check_bit("addr1", v1, a1);
        check_bit("oe4_n", 1'b0, p4oe);
        check_bit("oe1_n", 1'b0, p1oe);
        check_bit("oper", 1'b1, op);
    endtask

    task automatic ce_test();
        logic r;
        logic sp;
        r = rx;
        sp = spd;
        @(posedge clock_i);
        ce_i <= 1'b0;
        rx <= ~r;
        spd <= ~sp;
        repeat (3)
        begin
            @(negedge clock_i);
            check_bit("rx_led_hold", r, p4o);
            check_bit("speed_hold", sp, spo);
        end
        @(posedge clock_i);
        ce_i <= 1'b1;
    endtask

    task automatic rand_loop(input logic v4, input logic v1);
        repeat (40)
        begin
            rx_prev = rx;
            spd_prev = spd;
            rnd = lfsr_next(rnd);
            @(posedge clock_i);
            rx <= rnd[0];
            spd <= rnd[3];
            s4 <= rnd[5];
            @(negedge clock_i);
            check_bit("rx_led", rx_prev, p4o);
            check_bit("pad4", rx_prev, pad4);
            check_bit("speed", spd_prev, spo);
            check_bit("addr4", v4, a4);
            check_bit("addr1", v1, a1);
        end
    endtask

    task automatic coll_test();
        @(posedge clock_i);
        coll <= 1'b1;
        @(posedge clock_i);
        coll <= 1'b0;
        @(negedge clock_i);
        check_bit("coll_led", 1'b0, p1o);
        repeat (HOLD)
        begin
            @(negedge clock_i);
            check_bit("coll_led", 1'b1, p1o);
            check_bit("pad1", 1'b1, pad1);
        end
        @(negedge clock_i);
        check_bit("coll_led", 1'b0, p1o);
    endtask

    initial
    begin
        #20000;
        err_count++;
        final_report();
    end

    initial
    begin
        do_reset(1'b1, 1'b0);
        rand_loop(1'b1, 1'b0);
        ce_test();
        coll_test();
        rnd = lfsr_next(rnd);
        do_reset(rnd[2], ~rnd[2]);
        rand_loop(rnd[2], ~rnd[2]);
        coll_test();
        final_report();
    end
endmodule // test_strap_and_status_pin_logic
